/* pkg/decoder_regs.vh */
`ifndef DECODER_REGS_VH
`define DECODER_REGS_VH
// Word, address, tag and function widths.
`define WORD_W 8
`define ADDR_W 12
`define TAG_W 4
`define FUNC_W 6
// First-word fields.
`define FUNC_MSB 5
`define FUNC_LSB 0
`define SEL_MSB 7
`define SEL_LSB 6
// Storage sizes.
`define BASE_WORDS 12'h800
`define FULL_WORDS 13'h1000
// Storage cycle timing.
`define STORE_CYCLE_NS 4000
`define CLOCK_NS 10
// Function codes (hex, six bits).
`define OP_ERROR_HALT 6'h00
`define OP_SHIFT 6'h01
`define OP_ACC_TO_EXT 6'h02
`define OP_EXT_TO_ACC 6'h03
`define OP_ACC_TO_BUF_ENT 6'h04
`define OP_ACC_TO_BUF_EXIT 6'h05
`define OP_BUF_ENT_TO_ACC 6'h06
`define OP_CLEAR_BUF_CTRL 6'h07
`define OP_AND_IMM 6'h08
`define OP_AND_DIR 6'h09
`define OP_AND_IND 6'h0A
`define OP_CLEAR_INT 6'h0B
`define OP_OR_IMM 6'h0C
`define OP_OR_DIR 6'h0D
`define OP_OR_IND 6'h0E
`define OP_LOAD_IMM 6'h10
`define OP_LOAD_DIR 6'h11
`define OP_LOAD_IND 6'h12
`define OP_LOADC_DIR 6'h15
`define OP_LOADC_IND 6'h16
`define OP_ADD_IMM 6'h18
`define OP_ADD_DIR 6'h19
`define OP_ADD_IND 6'h1A
`define OP_SUB_IMM 6'h1C
`define OP_SUB_DIR 6'h1D
`define OP_SUB_IND 6'h1E
`define OP_STORE_DIR 6'h21
`define OP_STORE_IND 6'h22
`define OP_REPLACE_ADD 6'h29
`define OP_REPLACE_INC 6'h2D
`define OP_JUMP_ZERO 6'h30
`define OP_JUMP_NONZERO 6'h31
`define OP_JUMP_POS 6'h32
`define OP_JUMP_NEG 6'h33
`define OP_JUMP_ALWAYS 6'h34
`define OP_BUF_INPUT 6'h38
`define OP_BUF_OUTPUT 6'h39
`define OP_INPUT_BLOCK 6'h3A
`define OP_OUTPUT_BLOCK 6'h3B
`define OP_OUTPUT_IMM 6'h3C
`define OP_EXT_FUNCTION 6'h3D
`define OP_INPUT_TO_ACC 6'h3E
`define OP_HALT 6'h3F
// Addressing modes.
`define MODE_NONE 2'h0
`define MODE_IMM 2'h1
`define MODE_DIR 2'h2
`define MODE_IND 2'h3
// Operation classes.
`define CLS_NONE 5'h00
`define CLS_LOAD 5'h01
`define CLS_LOADC 5'h02
`define CLS_STORE 5'h03
`define CLS_ADD 5'h04
`define CLS_SUB 5'h05
`define CLS_OR 5'h06
`define CLS_AND 5'h07
`define CLS_REPL_ADD 5'h08
`define CLS_REPL_INC 5'h09
`define CLS_ACC_TO_EXT 5'h0A
`define CLS_EXT_TO_ACC 5'h0B
`define CLS_JUMP 5'h0C
`define CLS_CLEAR_INT 5'h0D
`define CLS_ERROR_HALT 5'h0E
`define CLS_HALT 5'h0F
`define CLS_EXT_FUNC 5'h10
`define CLS_IN_ACC 5'h11
`define CLS_IN_BLOCK 5'h12
`define CLS_OUT_IMM 5'h13
`define CLS_OUT_BLOCK 5'h14
`define CLS_BUF_ENT 5'h15
`define CLS_BUF_EXIT 5'h16
`define CLS_BUF_TO_ACC 5'h17
`define CLS_CLR_BUF 5'h18
`define CLS_BUF_IN 5'h19
`define CLS_BUF_OUT 5'h1A
`define CLS_SHIFT 5'h1B
// Jump conditions.
`define JC_ZERO 3'h0
`define JC_NONZERO 3'h1
`define JC_POS 3'h2
`define JC_NEG 3'h3
`define JC_ALWAYS 3'h4
// Reset values.
`define PC_RESET 12'h000
`define TAG_RESET 4'h0
`endif

/* design/function_map.v */
`include "decoder_regs.vh"
module function_map
(
  // First instruction word.
  input wire [7:0] first_word,
  // Decoded result.
  output reg [4:0] op_class,
  output reg [1:0] addr_mode,
  output reg [2:0] jump_cond,
  output reg unimplemented
);
  wire [5:0] func;
  assign func = first_word[`FUNC_MSB:`FUNC_LSB];
  always @*
  begin
    op_class = `CLS_NONE;
    addr_mode = `MODE_NONE;
    jump_cond = `JC_ALWAYS;
    unimplemented = 1'b0;
    case (func)
      `OP_LOAD_IMM: begin op_class = `CLS_LOAD; addr_mode = `MODE_IMM; end
      `OP_LOAD_DIR: begin op_class = `CLS_LOAD; addr_mode = `MODE_DIR; end
      `OP_LOAD_IND: begin op_class = `CLS_LOAD; addr_mode = `MODE_IND; end
      `OP_LOADC_DIR: begin op_class = `CLS_LOADC; addr_mode = `MODE_DIR; end
      `OP_LOADC_IND: begin op_class = `CLS_LOADC; addr_mode = `MODE_IND; end
      `OP_STORE_DIR: begin op_class = `CLS_STORE; addr_mode = `MODE_DIR; end
      `OP_STORE_IND: begin op_class = `CLS_STORE; addr_mode = `MODE_IND; end
      `OP_ADD_IMM: begin op_class = `CLS_ADD; addr_mode = `MODE_IMM; end
      `OP_ADD_DIR: begin op_class = `CLS_ADD; addr_mode = `MODE_DIR; end
      `OP_ADD_IND: begin op_class = `CLS_ADD; addr_mode = `MODE_IND; end
      `OP_SUB_IMM: begin op_class = `CLS_SUB; addr_mode = `MODE_IMM; end
      `OP_SUB_DIR: begin op_class = `CLS_SUB; addr_mode = `MODE_DIR; end
      `OP_SUB_IND: begin op_class = `CLS_SUB; addr_mode = `MODE_IND; end
      `OP_REPLACE_INC: begin op_class = `CLS_REPL_INC; addr_mode = `MODE_DIR; end
      `OP_REPLACE_ADD: begin op_class = `CLS_REPL_ADD; addr_mode = `MODE_DIR; end
      `OP_OR_IMM: begin op_class = `CLS_OR; addr_mode = `MODE_IMM; end
      `OP_OR_DIR: begin op_class = `CLS_OR; addr_mode = `MODE_DIR; end
      `OP_OR_IND: begin op_class = `CLS_OR; addr_mode = `MODE_IND; end
      `OP_AND_IMM: begin op_class = `CLS_AND; addr_mode = `MODE_IMM; end
      `OP_AND_DIR: begin op_class = `CLS_AND; addr_mode = `MODE_DIR; end
      `OP_AND_IND: begin op_class = `CLS_AND; addr_mode = `MODE_IND; end
      `OP_ACC_TO_EXT: op_class = `CLS_ACC_TO_EXT;
      `OP_EXT_TO_ACC: op_class = `CLS_EXT_TO_ACC;
      `OP_JUMP_ZERO: begin op_class = `CLS_JUMP; jump_cond = `JC_ZERO; end
      `OP_JUMP_NONZERO: begin op_class = `CLS_JUMP; jump_cond = `JC_NONZERO; end
      `OP_JUMP_POS: begin op_class = `CLS_JUMP; jump_cond = `JC_POS; end
      `OP_JUMP_NEG: begin op_class = `CLS_JUMP; jump_cond = `JC_NEG; end
      `OP_JUMP_ALWAYS: begin op_class = `CLS_JUMP; jump_cond = `JC_ALWAYS; end
      `OP_CLEAR_INT: op_class = `CLS_CLEAR_INT;
      `OP_ERROR_HALT: op_class = `CLS_ERROR_HALT;
      `OP_HALT: op_class = `CLS_HALT;
      `OP_EXT_FUNCTION: begin op_class = `CLS_EXT_FUNC; addr_mode = `MODE_IMM; end
      `OP_INPUT_TO_ACC: op_class = `CLS_IN_ACC;
      `OP_INPUT_BLOCK: begin op_class = `CLS_IN_BLOCK; addr_mode = `MODE_DIR; end
      `OP_OUTPUT_IMM: begin op_class = `CLS_OUT_IMM; addr_mode = `MODE_IMM; end
      `OP_OUTPUT_BLOCK: begin op_class = `CLS_OUT_BLOCK; addr_mode = `MODE_DIR; end
      `OP_ACC_TO_BUF_ENT: op_class = `CLS_BUF_ENT;
      `OP_ACC_TO_BUF_EXIT: op_class = `CLS_BUF_EXIT;
      `OP_BUF_ENT_TO_ACC: op_class = `CLS_BUF_TO_ACC;
      `OP_CLEAR_BUF_CTRL: op_class = `CLS_CLR_BUF;
      `OP_BUF_INPUT: begin op_class = `CLS_BUF_IN; addr_mode = `MODE_DIR; end
      `OP_BUF_OUTPUT: begin op_class = `CLS_BUF_OUT; addr_mode = `MODE_DIR; end
      `OP_SHIFT: op_class = `CLS_SHIFT;
      default: unimplemented = 1'b1;
    endcase
  end
endmodule

/* design/cycle_timer.v */
`include "decoder_regs.vh"
module cycle_timer
(
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Start of a storage reference and its end.
  input wire start,
  output reg done
);
  localparam [31:0] CYCLE_WIDE = `STORE_CYCLE_NS / `CLOCK_NS;
  localparam [8:0] CYCLE_COUNT = CYCLE_WIDE[8:0];
  reg [8:0] count;
  reg running;
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      count <= 9'h000;
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !running)
      begin
        running <= 1'b1;
        count <= CYCLE_COUNT - 9'h001;
      end
      else if (running)
      begin
        if (count == 9'h001)
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
        count <= count - 9'h001;
      end
    end
  end
endmodule

/* design/instruction_decoder.v */
`include "decoder_regs.vh"
module instruction_decoder
(
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Core memory read port.
  output reg mem_read,
  output reg [11:0] mem_addr,
  input wire [7:0] mem_data,
  // Storage size option.
  input wire large_store,
  // Execution side: accumulator state and tag writes.
  input wire [7:0] acc,
  input wire tag_write,
  input wire [1:0] tag_write_sel,
  input wire [3:0] tag_write_data,
  input wire go,
  // Decoded instruction.
  output reg instr_valid,
  output reg [5:0] func_code,
  output reg [1:0] tag_select,
  output reg [4:0] op_class,
  output reg [1:0] addr_mode,
  output reg [7:0] operand,
  output reg [11:0] operand_addr,
  output reg jump_taken,
  output reg unimplemented,
  output reg [11:0] pc,
  output reg halted
);
  localparam [2:0] ST_FETCH1 = 3'h0;
  localparam [2:0] ST_FETCH2 = 3'h1;
  localparam [2:0] ST_INDIRECT = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;
  localparam [2:0] ST_HALT = 3'h4;
  localparam [2:0] ST_WAIT = 3'h5;
  reg [2:0] state;
  reg [7:0] first_word;
  reg [7:0] second_word;
  reg [3:0] tag_reg [1:3];
  reg [3:0] sel_tag;
  reg start;
  reg cond_met;
  reg [11:0] next_pc;
  reg [11:0] wrap_mask;
  wire done;
  wire [4:0] dec_class;
  wire [1:0] dec_mode;
  wire [2:0] dec_cond;
  wire dec_unimpl;
  // Word decoding of the captured first word.
  function_map u_map
  (
    .first_word(first_word),
    .op_class(dec_class),
    .addr_mode(dec_mode),
    .jump_cond(dec_cond),
    .unimplemented(dec_unimpl)
  );
  // Storage cycle pacing.
  cycle_timer u_timer
  (
    .clock(clock),
    .rst_b(rst_b),
    .start(start),
    .done(done)
  );
  // Tag registers 1 to 3, each four bits.
  genvar gi;
  generate
    for (gi = 1; gi <= 3; gi = gi + 1)
    begin : g_tag
      localparam [31:0] TAG_NUM = gi;
      always @(posedge clock)
      begin
        if (!rst_b)
          tag_reg[gi] <= `TAG_RESET;
        else if (tag_write && tag_write_sel == TAG_NUM[1:0])
          tag_reg[gi] <= tag_write_data;
      end
    end
  endgenerate
  // Tag zero selects no extension.
  always @*
  begin
    sel_tag = `TAG_RESET;
    if (first_word[`SEL_MSB:`SEL_LSB] != 2'h0)
      sel_tag = tag_reg[first_word[`SEL_MSB:`SEL_LSB]];
  end
  // Jump condition on the accumulator.
  always @*
  begin
    case (dec_cond)
      `JC_ZERO: cond_met = (acc == 8'h00);
      `JC_NONZERO: cond_met = (acc != 8'h00);
      `JC_POS: cond_met = !acc[7];
      `JC_NEG: cond_met = acc[7];
      default: cond_met = 1'b1;
    endcase
  end
  // Address wrap for the base or full store.
  always @*
  begin
    wrap_mask = large_store ? 12'hFFF : (`BASE_WORDS - 12'h001);
  end
  // Sequencing.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      state <= ST_FETCH1;
      first_word <= 8'h00;
      second_word <= 8'h00;
      start <= 1'b0;
      mem_read <= 1'b0;
      mem_addr <= `PC_RESET;
      instr_valid <= 1'b0;
      func_code <= 6'h00;
      tag_select <= 2'h0;
      op_class <= `CLS_NONE;
      addr_mode <= `MODE_NONE;
      operand <= 8'h00;
      operand_addr <= 12'h000;
      jump_taken <= 1'b0;
      unimplemented <= 1'b0;
      pc <= `PC_RESET;
      next_pc <= `PC_RESET;
      halted <= 1'b0;
    end
    else
    begin
      start <= 1'b0;
      instr_valid <= 1'b0;
      case (state)
        ST_FETCH1:
        begin
          if (!mem_read)
          begin
            mem_read <= 1'b1;
            mem_addr <= pc & wrap_mask;
            start <= 1'b1;
          end
          else if (done)
          begin
            first_word <= mem_data;
            mem_addr <= (pc + 12'h001) & wrap_mask;
            start <= 1'b1;
            state <= ST_FETCH2;
          end
        end
        ST_FETCH2:
        begin
          if (done)
          begin
            second_word <= mem_data;
            if (dec_mode == `MODE_IND)
            begin
              mem_addr <= {4'h0, mem_data};
              start <= 1'b1;
              state <= ST_INDIRECT;
            end
            else
            begin
              mem_read <= 1'b0;
              operand <= mem_data;
              operand_addr <= {sel_tag, mem_data} & wrap_mask;
              state <= ST_DONE;
            end
          end
        end
        ST_INDIRECT:
        begin
          if (done)
          begin
            mem_read <= 1'b0;
            operand <= second_word;
            operand_addr <= {sel_tag, mem_data} & wrap_mask;
            state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          instr_valid <= 1'b1;
          func_code <= first_word[`FUNC_MSB:`FUNC_LSB];
          tag_select <= first_word[`SEL_MSB:`SEL_LSB];
          op_class <= dec_class;
          addr_mode <= dec_mode;
          unimplemented <= dec_unimpl;
          jump_taken <= (dec_class == `CLS_JUMP) && cond_met;
          if (dec_class == `CLS_JUMP && cond_met)
            next_pc <= {sel_tag, second_word} & wrap_mask;
          else
            next_pc <= (pc + 12'h002) & wrap_mask;
          if (dec_class == `CLS_HALT || dec_class == `CLS_ERROR_HALT || dec_unimpl)
          begin
            halted <= 1'b1;
            state <= ST_HALT;
          end
          else
            state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (go)
          begin
            pc <= next_pc;
            state <= ST_FETCH1;
          end
        end
        ST_HALT:
          state <= ST_HALT;
        default: state <= ST_FETCH1;
      endcase
    end
  end
endmodule

/* verif/instruction_decoder_asserts.sv */
`include "decoder_regs.vh"
module instruction_decoder_asserts (
  // Clock and reset.
  input logic clock,
  input logic rst_b,
  // Storage port.
  input logic mem_read,
  input logic [11:0] mem_addr,
  // Decoded instruction.
  input logic instr_valid,
  input logic [5:0] func_code,
  input logic [1:0] tag_select,
  input logic [4:0] op_class,
  input logic [1:0] addr_mode,
  input logic [7:0] operand,
  input logic [11:0] operand_addr,
  input logic unimplemented,
  input logic [11:0] pc,
  input logic halted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] since;
  logic was_read;
  logic pending;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence fetch_start;
    $rose(mem_read);
  endsequence
  sequence decoded;
    instr_valid;
  endsequence
  sequence addr_moved;
    mem_read && $changed(mem_addr);
  endsequence
  sequence direct_done;
    instr_valid && addr_mode == `MODE_DIR;
  endsequence
  sequence untagged;
    instr_valid && addr_mode == `MODE_DIR && tag_select == 2'h0;
  endsequence
  sequence alu_done;
    instr_valid && op_class >= 5'h01 && op_class <= 5'h07;
  endsequence
  // Counts cycles since the last fetch began and marks a fetch still awaiting its decode.
  always @(posedge clock)
  begin
    was_read <= mem_read;
    if (!rst_b || (mem_read && !was_read))
      since <= 11'h000;
    else if (since != 11'h7FF)
      since <= since + 11'h001;
    if (!rst_b)
      pending <= 1'b0;
    else if (mem_read && !was_read)
      pending <= 1'b1;
    else if (instr_valid)
      pending <= 1'b0;
  end
  chk_answer_time: assert property (pending |-> since <= 11'h4BA)
    else $error("decode did not follow the fetch in time");
  chk_not_early: assert property (decoded |-> since >= 11'h300)
    else $error("decode came too soon");
  chk_valid_pulse: assert property (decoded |=> !instr_valid)
    else $error("valid pulse too long");
  chk_fetch_at_pc: assert property (fetch_start |-> mem_addr == pc)
    else $error("fetch not at program counter");
  chk_addr_hold: assert property (addr_moved |=> $stable(mem_addr) [*8])
    else $error("address not held");
  chk_direct_low: assert property (direct_done |-> operand_addr[7:0] == operand)
    else $error("direct low byte wrong");
  chk_tag_zero: assert property (untagged |-> operand_addr[11:8] == 4'h0)
    else $error("tag zero upper bits wrong");
  chk_mode_map: assert property (alu_done |-> addr_mode == func_code[1:0] + 2'h1)
    else $error("mode does not follow code");
  chk_halt_sticky: assert property (halted |=> halted)
    else $error("halt not sticky");
  chk_unimpl_halts: assert property (instr_valid && unimplemented |=> halted)
    else $error("undefined code did not halt");
  chk_no_fetch_halt: assert property (halted |-> !$rose(mem_read))
    else $error("fetch while halted");
endmodule
bind instruction_decoder instruction_decoder_asserts u_instruction_decoder_asserts (
  .clock(clock), .rst_b(rst_b), .mem_read(mem_read), .mem_addr(mem_addr),
  .instr_valid(instr_valid), .func_code(func_code), .tag_select(tag_select),
  .op_class(op_class), .addr_mode(addr_mode), .operand(operand),
  .operand_addr(operand_addr), .unimplemented(unimplemented), .pc(pc), .halted(halted));

/* verif/core_memory.sv */
module core_memory (
  // Clock.
  input logic clock,
  // Read port.
  input logic mem_read,
  input logic [11:0] mem_addr,
  input logic large_store,
  output logic [7:0] mem_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:4095];
  logic [7:0] last = 8'h5A;
  // Outside a reference the line shows the inverse of the last word.
  always @(posedge clock)
    if (mem_read)
      last <= mem_data;
  // A small store repeats every 2048 words.
  assign mem_data = mem_read ? store[mem_addr & (large_store ? 12'hFFF : 12'h7FF)] : ~last;
endmodule

/* verif/two_word_instruction_decoder_tb_top.sv */
`include "decoder_regs.vh"
module two_word_instruction_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic large_store = 1'b1;
  logic [7:0] acc = 8'h00;
  logic tag_write = 1'b0;
  logic [1:0] tag_write_sel = 2'h0;
  logic [3:0] tag_write_data = 4'h0;
  logic go = 1'b0;
  logic mem_read, instr_valid, jump_taken, unimplemented, halted;
  logic [11:0] mem_addr, operand_addr, pc, exp_pc;
  logic [7:0] mem_data, operand;
  logic [5:0] func_code;
  logic [1:0] tag_select, addr_mode;
  logic [4:0] op_class;
  logic [3:0] tags [0:3];
  int n_fail = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  instruction_decoder u_instruction_decoder (.clock(clock), .rst_b(rst_b),
    .mem_read(mem_read), .mem_addr(mem_addr), .mem_data(mem_data), .large_store(large_store),
    .acc(acc), .tag_write(tag_write), .tag_write_sel(tag_write_sel),
    .tag_write_data(tag_write_data), .go(go), .instr_valid(instr_valid),
    .func_code(func_code), .tag_select(tag_select), .op_class(op_class),
    .addr_mode(addr_mode), .operand(operand), .operand_addr(operand_addr),
    .jump_taken(jump_taken), .unimplemented(unimplemented), .pc(pc), .halted(halted));
  core_memory u_core_memory (.clock(clock), .mem_read(mem_read), .mem_addr(mem_addr),
    .large_store(large_store), .mem_data(mem_data));
  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task automatic await(input bit valid, input int limit);
    int i;
    for (i = 0; i < limit; i++)
    begin
      @(posedge clock);
      #1;
      if ((valid ? instr_valid : mem_read) === 1'b1)
        return;
    end
    n_fail++;
    $display("unexpected at %0t: wait ran out", $time);
    end_of_test();
  endtask
  function automatic logic [4:0] exp_class(input logic [5:0] f);
    case (f)
      6'h08, 6'h09, 6'h0A: return 5'h07;
      6'h0C, 6'h0D, 6'h0E: return 5'h06;
      6'h10, 6'h11, 6'h12: return 5'h01;
      6'h15, 6'h16: return 5'h02;
      6'h18, 6'h19, 6'h1A: return 5'h04;
      6'h1C, 6'h1D, 6'h1E: return 5'h05;
      6'h21, 6'h22: return 5'h03;
      6'h29: return 5'h08;
      6'h2D: return 5'h09;
      6'h02: return 5'h0A;
      6'h03: return 5'h0B;
      6'h30, 6'h31, 6'h32, 6'h33, 6'h34: return 5'h0C;
      6'h0B: return 5'h0D;
      6'h00: return 5'h0E;
      6'h3F: return 5'h0F;
      6'h3D: return 5'h10;
      6'h3E: return 5'h11;
      6'h3A: return 5'h12;
      6'h3C: return 5'h13;
      6'h3B: return 5'h14;
      6'h04: return 5'h15;
      6'h05: return 5'h16;
      6'h06: return 5'h17;
      6'h07: return 5'h18;
      6'h38: return 5'h19;
      6'h39: return 5'h1A;
      6'h01: return 5'h1B;
      default: return 5'h1F;
    endcase
  endfunction
  // Top bit set when the mode is known for this code.
  function automatic logic [2:0] exp_mode(input logic [5:0] f, input logic [4:0] c);
    if (c >= 5'h01 && c <= 5'h07)
      return {1'b1, f[1:0] + 2'h1};
    if (f == 6'h29 || f == 6'h2D || f == 6'h3A || f == 6'h3B)
      return {1'b1, `MODE_DIR};
    return 3'h0;
  endfunction
  task automatic put_tag(input logic [1:0] sel, input logic [3:0] val);
    @(posedge clock);
    tag_write <= 1'b1;
    tag_write_sel <= sel;
    tag_write_data <= val;
    if (sel != 2'h0)
      tags[sel] = val;
    @(posedge clock);
    tag_write <= 1'b0;
  endtask
  task automatic begin_run(input logic big);
    int k;
    @(posedge clock);
    rst_b <= 1'b0;
    large_store <= big;
    go <= 1'b0;
    exp_pc = 12'h000;
    tags = '{default: 4'h0};
    repeat (4) @(posedge clock);
    #1;
    check(halted, 1'b0);
    check(pc, 12'h000);
    @(posedge clock);
    rst_b <= 1'b1;
    put_tag(2'h0, 4'hF);
    for (k = 1; k < 4; k++)
      put_tag(2'(k), 4'($urandom));
  endtask
  task automatic run_one(input logic [5:0] f, input logic [1:0] sel, input logic [7:0] e);
    logic [4:0] c;
    logic [2:0] m;
    logic [7:0] a;
    logic [11:0] mask;
    logic [11:0] ea;
    logic take;
    c = exp_class(f);
    m = exp_mode(f, c);
    mask = large_store ? 12'hFFF : 12'h7FF;
    a = ($urandom % 4 == 0) ? 8'h00 : {7'($urandom), 1'b0};
    if (m == {1'b1, `MODE_IMM})
      sel = 2'h0;
    u_core_memory.store[e] = 8'($urandom);
    u_core_memory.store[exp_pc] = {sel, f};
    u_core_memory.store[(exp_pc + 12'h1) & mask] = e;
    @(posedge clock);
    acc <= a;
    go <= 1'b1;
    await(1'b0, 20);
    check(mem_addr, exp_pc);
    check(pc, exp_pc);
    @(posedge clock);
    go <= 1'b0;
    await(1'b1, 1400);
    check(func_code, f);
    check(tag_select, sel);
    check(operand, e);
    check(unimplemented, c == 5'h1F);
    if (c != 5'h1F)
      check(op_class, c);
    if (m[2])
      check(addr_mode, m[1:0]);
    ea = {tags[sel], m[1:0] == `MODE_IND ? u_core_memory.store[e] : e};
    if (m[2] && m[1:0] != `MODE_IMM)
      check(operand_addr & mask, ea & mask);
    take = f == 6'h34 || (f == 6'h30 && a == 8'h00) || (f == 6'h31 && a != 8'h00)
      || (f == 6'h32 && !a[7]) || (f == 6'h33 && a[7]);
    if (c == 5'h0C)
      check(jump_taken, take);
    exp_pc = (take ? ea : exp_pc + 12'h2) & mask;
    @(posedge clock);
    #1;
    check(halted, f == 6'h00 || f == 6'h3F || c == 5'h1F);
  endtask
  initial
  begin
    int f;
    void'($urandom(76935));
    begin_run(1'b0);
    put_tag(2'h1, 4'h7);
    run_one(6'h34, 2'h1, 8'hFE);
    run_one(6'h10, 2'h0, 8'hFF);
    for (f = 0; f < 64; f++)
    begin
      run_one(6'(f), 2'($urandom), 8'($urandom));
      if (exp_class(6'(f)) == 5'h1F || f == 0 || f >= 56)
        begin_run(1'($urandom));
    end
    end_of_test();
  end
endmodule
